// ### rtl/acrc_cfg.svh
// constants for the converter channel and reference control block
//----------------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------------
// Functional notes
// - ten-bit code equals input times 1024 over reference
// - result registers loaded when done flag rises
// - channel and reference frozen during a conversion
// - reference code: pin, supply, reserved, internal 1.1V
// - left justify changes data view immediately
// - select register bit 4 always reads zero
// - channel codes: pins 0-7, reserved 8-13, bandgap 14, ground 15
// - enable bit powers converter up or down
// - clearing enable aborts conversion in progress
// - start bit reads one while converting, zero ignored
// - update sets done flag; vector or write-one clears
// - three-bit prescaler divides by 2 to 128
// - low byte read freezes result until high read
`ifndef ACRC_CFG_SVH
`define ACRC_CFG_SVH

//----------------------------------------------------------------------
// register offsets
//----------------------------------------------------------------------
`define ACRC_OFS_SELECT 4'h0
`define ACRC_OFS_CTRL 4'h1
`define ACRC_OFS_RES_LOW 4'h2
`define ACRC_OFS_RES_HIGH 4'h3
`define ACRC_OFS_IRQ_STATUS 4'h4
`define ACRC_OFS_IRQ_MASK 4'h5

//----------------------------------------------------------------------
// field positions
//----------------------------------------------------------------------
`define ACRC_SEL_REF_HI 7
`define ACRC_SEL_REF_LO 6
`define ACRC_SEL_LEFT 5
`define ACRC_SEL_UNUSED 4
`define ACRC_CTL_ON 7
`define ACRC_CTL_START 6
`define ACRC_CTL_AUTO 5
`define ACRC_CTL_DONE 4
`define ACRC_CTL_IRQ_EN 3

//----------------------------------------------------------------------
// reset values and timing counts
//----------------------------------------------------------------------
`define ACRC_RST_SELECT 8'h00
`define ACRC_RST_CTRL 8'h00
`define ACRC_FIRST_CYCLES 5'h19
`define ACRC_NORMAL_CYCLES 5'h0D
`define ACRC_CODE_ZERO 10'h000
`define ACRC_CODE_FULL 10'h3FF

`endif

// ### rtl/acrc_pkg.sv
// types for the converter channel and reference control block
package acrc_pkg;

    //------------------------------------------------------------------
    // reference choice decode
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACRC_REF_PIN = 2'h0,
        ACRC_REF_SUPPLY = 2'h1,
        ACRC_REF_RESERVED = 2'h2,
        ACRC_REF_INTERNAL = 2'h3
    } acrc_ref_type;

    //------------------------------------------------------------------
    // conversion sequencer states, one-hot
    //------------------------------------------------------------------
    typedef enum logic [2:0] {
        ACRC_ST_OFF = 3'h1,
        ACRC_ST_IDLE = 3'h2,
        ACRC_ST_CONV = 3'h4
    } acrc_state_type;

endpackage : acrc_pkg

// ### rtl/acrc_prescaler.sv
// converter clock prescaler producing one-cycle tick pulses
`timescale 1ns/1ps
`include "acrc_cfg.svh"
module acrc_prescaler #(
    parameter int CNT_W = 7
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // control
    input wire logic run,
    input wire logic [2:0] divide_sel,
    // tick out
    output logic tick
);

    logic [CNT_W-1:0] count_ff;  // free counter while running
    logic [CNT_W-1:0] nxt_count;
    logic [CNT_W-1:0] div_mask;  // terminal mask for chosen ratio
    logic [2:0] shift_amt;       // log2 of division factor

    // codes 0 and 1 both divide by two
    assign shift_amt = (divide_sel == 3'h0) ? 3'h1 : divide_sel;
    assign div_mask = CNT_W'((8'h01 << shift_amt) - 8'h01);
    assign nxt_count = run ? CNT_W'(count_ff + 1'b1) : '0;
    assign tick = run && ((count_ff & div_mask) == div_mask);

    //------------------------------------------------------------------
    // counter
    //------------------------------------------------------------------
    // held at zero whenever run is low, i.e. outside a conversion
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_ff <= '0;
        else if (clk_en)
            count_ff <= nxt_count;
    end

endmodule : acrc_prescaler

// ### rtl/acrc_top.sv
// converter channel, reference and result control top level
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "acrc_cfg.svh"
module acrc_top #(
    parameter int RES_W = 10,
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // interrupt
    input wire logic vector_taken,
    output logic irq,
    // analog side
    input wire logic [RES_W-1:0] analog_code,
    output logic analog_power,
    output logic sample_hold,
    output logic [1:0] reference_choice,
    output logic ref_internal_on,
    output logic [PINS-1:0] pin_select,
    output logic bandgap_select,
    output logic ground_select
);

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    acrc_pkg::acrc_state_type state_ff, nxt_state; // sequencer
    logic [7:0] select_ff;       // software view of select register
    logic [7:0] nxt_select;
    logic [1:0] ref_live_ff;     // reference applied to converter
    logic [3:0] chan_live_ff;    // channel applied to converter
    logic converter_on_ff;       // enable bit
    logic auto_trigger_on_ff;    // stored only
    logic done_flag_ff;          // completion flag
    logic irq_en_ff;             // done interrupt enable
    logic [2:0] clock_divide_select_ff;
    logic first_ff;              // next conversion is the long one
    logic [4:0] tick_cnt_ff;     // converter clocks in conversion
    logic [RES_W-1:0] result_ff; // completed code
    logic locked_ff;             // low byte read, high byte pending
    logic [7:0] irq_status_ff;   // sticky events, read clears
    logic [7:0] irq_mask_ff;     // unmasked events reach irq
    logic [7:0] rdata_ff;
    logic [RES_W-1:0] code_s1_ff, code_s2_ff; // input synchroniser

    //------------------------------------------------------------------
    // decode
    //------------------------------------------------------------------
    // one pulse per converter clock from the prescaler
    wire tick;
    wire wr_sel = reg_wr && (reg_addr == `ACRC_OFS_SELECT);
    wire wr_ctl = reg_wr && (reg_addr == `ACRC_OFS_CTRL);
    wire wr_msk = reg_wr && (reg_addr == `ACRC_OFS_IRQ_MASK);
    wire rd_low = reg_rd && (reg_addr == `ACRC_OFS_RES_LOW);
    wire rd_high = reg_rd && (reg_addr == `ACRC_OFS_RES_HIGH);
    wire rd_sts = reg_rd && (reg_addr == `ACRC_OFS_IRQ_STATUS);
    wire converting = (state_ff == acrc_pkg::ACRC_ST_CONV);
    wire new_on = wr_ctl ? reg_wdata[`ACRC_CTL_ON] : converter_on_ff;
    wire start_req = wr_ctl && reg_wdata[`ACRC_CTL_START];
    // clearing enable while busy kills the conversion, no result kept
    wire abort = converting && !new_on;
    wire [4:0] conv_len = first_ff ? `ACRC_FIRST_CYCLES
                                   : `ACRC_NORMAL_CYCLES;
    wire conv_end = converting && tick && (tick_cnt_ff == conv_len - 5'h01);
    wire complete = conv_end && !abort;
    // a pending low byte read holds the old result
    wire load_result = complete && !locked_ff;
    wire clr_done = wr_ctl && reg_wdata[`ACRC_CTL_DONE];
    wire set_done = complete;
    wire left = select_ff[`ACRC_SEL_LEFT];

    // justified data view follows left justify at once
    wire [15:0] right_view = {6'h00, result_ff};
    wire [15:0] left_view = {result_ff, 6'h00};
    wire [15:0] data_view = left ? left_view : right_view;

    // bit 4 of select always reads zero
    wire [7:0] sel_read = {select_ff[7:5], 1'b0, select_ff[3:0]};
    wire [7:0] ctl_read = {converter_on_ff, converting, auto_trigger_on_ff,
                           done_flag_ff, irq_en_ff, clock_divide_select_ff};
    wire [7:0] rd_mux =
        (reg_addr == `ACRC_OFS_SELECT) ? sel_read :
        (reg_addr == `ACRC_OFS_CTRL) ? ctl_read :
        (reg_addr == `ACRC_OFS_RES_LOW) ? data_view[7:0] :
        (reg_addr == `ACRC_OFS_RES_HIGH) ? data_view[15:8] :
        (reg_addr == `ACRC_OFS_IRQ_STATUS) ? irq_status_ff :
        (reg_addr == `ACRC_OFS_IRQ_MASK) ? irq_mask_ff : 8'h00;

    // events: bit0 done, bit1 abort
    wire [7:0] events = {6'h00, abort, complete};
    assign nxt_select = {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};

    //------------------------------------------------------------------
    // prescaler
    //------------------------------------------------------------------
    acrc_prescaler #(
        .CNT_W(7)
    ) u_prescaler (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .run(converting),
        .divide_sel(clock_divide_select_ff),
        .tick(tick)
    );

    //------------------------------------------------------------------
    // sequencer next state
    //------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            acrc_pkg::ACRC_ST_OFF:
            begin
                // enable powers up; start with enable goes straight on
                if (new_on && start_req)
                    nxt_state = acrc_pkg::ACRC_ST_CONV;
                else if (new_on)
                    nxt_state = acrc_pkg::ACRC_ST_IDLE;
            end
            acrc_pkg::ACRC_ST_IDLE:
            begin
                if (!new_on)
                    nxt_state = acrc_pkg::ACRC_ST_OFF;
                else if (start_req)
                    nxt_state = acrc_pkg::ACRC_ST_CONV;
            end
            acrc_pkg::ACRC_ST_CONV:
            begin
                if (abort)
                    nxt_state = acrc_pkg::ACRC_ST_OFF;
                else if (conv_end)
                    nxt_state = acrc_pkg::ACRC_ST_IDLE;
            end
            default:
                nxt_state = acrc_pkg::ACRC_ST_OFF;
        endcase
    end

    //------------------------------------------------------------------
    // sequencer and counter
    //------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= acrc_pkg::ACRC_ST_OFF;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // counts converter clocks; cleared outside a conversion
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt_ff <= 5'h00;
        else if (clk_en)
        begin
            if (!converting || conv_end)
                tick_cnt_ff <= 5'h00;
            else if (tick)
                tick_cnt_ff <= tick_cnt_ff + 5'h01;
        end
    end

    // first conversion after enabling takes the long count
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            first_ff <= 1'b1;
        else if (clk_en)
        begin
            if (!new_on)
                first_ff <= 1'b1;
            else if (complete)
                first_ff <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // select register and live copies
    //------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            select_ff <= `ACRC_RST_SELECT;
        else if (clk_en && wr_sel)
            select_ff <= nxt_select;
    end

    // live copy tracks software value except during a conversion
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_live_ff <= 2'h0;
            chan_live_ff <= 4'h0;
        end
        else if (clk_en && (!converting || conv_end))
        begin
            ref_live_ff <= select_ff[`ACRC_SEL_REF_HI:`ACRC_SEL_REF_LO];
            chan_live_ff <= select_ff[3:0];
        end
    end

    //------------------------------------------------------------------
    // control register
    //------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            converter_on_ff <= 1'(`ACRC_RST_CTRL >> `ACRC_CTL_ON);
            auto_trigger_on_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            clock_divide_select_ff <= 3'h0;
        end
        else if (clk_en && wr_ctl)
        begin
            converter_on_ff <= reg_wdata[`ACRC_CTL_ON];
            auto_trigger_on_ff <= reg_wdata[`ACRC_CTL_AUTO];
            irq_en_ff <= reg_wdata[`ACRC_CTL_IRQ_EN];
            clock_divide_select_ff <= reg_wdata[2:0];
        end
    end

    // done flag: set wins over vector or write-one clear
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            done_flag_ff <= 1'b0;
        else if (clk_en)
        begin
            if (set_done)
                done_flag_ff <= 1'b1;
            else if (clr_done || vector_taken)
                done_flag_ff <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // result capture
    //------------------------------------------------------------------
    // two-flop synchroniser for the analog code bus
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_s1_ff <= '0;
            code_s2_ff <= '0;
        end
        else if (clk_en)
        begin
            code_s1_ff <= analog_code;
            code_s2_ff <= code_s1_ff;
        end
    end

    // result loaded in the same edge the done flag sets, unless a low byte read is pending
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            result_ff <= `ACRC_CODE_ZERO;
        else if (clk_en && load_result)
            result_ff <= code_s2_ff;
    end

    // low byte read locks, high byte read unlocks
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            locked_ff <= 1'b0;
        else if (clk_en)
        begin
            if (rd_high)
                locked_ff <= 1'b0;
            else if (rd_low)
                locked_ff <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // interrupt status and mask
    //------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_status_ff <= 8'h00;
        else if (clk_en)
            irq_status_ff <= (rd_sts ? 8'h00 : irq_status_ff) | events;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_mask_ff <= 8'h00;
        else if (clk_en && wr_msk)
            irq_mask_ff <= reg_wdata;
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_ff <= 8'h00;
        else if (clk_en)
            rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    // level interrupt from sticky status, plus done flag with enable
    // the enable bit gates only the done flag path, not the status
    assign irq = |(irq_status_ff & irq_mask_ff) ||
                 (done_flag_ff && irq_en_ff);
    assign reg_rdata = rdata_ff;
    assign analog_power = converter_on_ff;
    assign sample_hold = converting;
    assign reference_choice = ref_live_ff;
    assign ref_internal_on = (ref_live_ff == acrc_pkg::ACRC_REF_INTERNAL);

    // one select line per input pin
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            assign pin_select[gi] = (chan_live_ff == 4'(gi));
        end
    endgenerate
    assign bandgap_select = (chan_live_ff == 4'hE);
    assign ground_select = (chan_live_ff == 4'hF);

endmodule : acrc_top

// ### tb/acrc_monitor.sv
// checker for the converter control block, seen from its ports
`timescale 1ns/1ps
module acrc_monitor #(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // analog side
    input wire logic analog_power,
    input wire logic sample_hold,
    input wire logic [1:0] reference_choice,
    input wire logic ref_internal_on,
    input wire logic [PINS-1:0] pin_select,
    input wire logic bandgap_select,
    input wire logic ground_select
);
    //------------------------------------------------------------------
    // all checks on the core clock
    //------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    chk_ref_decode: assert property (
        ref_internal_on == (reference_choice == 2'h3))
        else $error("internal reference enable wrong");
    chk_sel_onehot: assert property (
        $onehot0({pin_select, bandgap_select, ground_select}))
        else $error("more than one input selected");
    chk_power_hold: assert property (
        sample_hold |-> analog_power)
        else $error("converting while powered down");
    chk_sel_locked: assert property (
        sample_hold && $past(sample_hold) |-> $stable(reference_choice)
        && $stable({pin_select, bandgap_select, ground_select}))
        else $error("selection moved during conversion");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unused_bit: assert property (
        $past(reg_rd) && $past(reg_addr) == 4'h0 |-> !reg_rdata[4])
        else $error("unused select bit read as one");
    chk_busy_bit: assert property (
        $past(reg_rd) && $past(reg_addr) == 4'h1 |->
        reg_rdata[7:6] == {$past(analog_power), $past(sample_hold)})
        else $error("enable or busy bit wrong");
    chk_unmapped_read: assert property (
        $past(reg_rd) && $past(reg_addr) > 4'h5 |-> reg_rdata == 8'h00)
        else $error("unmapped index not zero");
    chk_conv_min: assert property (
        $rose(sample_hold) |-> (sample_hold || !analog_power)[*8])
        else $error("conversion ended too early");
endmodule : acrc_monitor

bind acrc_top acrc_monitor #(.PINS(PINS)) mon_u (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_power(analog_power),
    .sample_hold(sample_hold), .reference_choice(reference_choice),
    .ref_internal_on(ref_internal_on), .pin_select(pin_select),
    .bandgap_select(bandgap_select), .ground_select(ground_select));

// ### tb/acrc_analog_model.sv
// behavioural model of the sampling and conversion circuitry
`timescale 1ns/1ps
module acrc_analog_model (
    // clock
    input wire logic core_clk,
    // controls from the block
    input wire logic analog_power,
    input wire logic sample_hold,
    input wire logic [7:0] pin_select,
    input wire logic bandgap_select,
    // levels, ten bits per pin
    input wire logic [79:0] pin_level,
    input wire logic [9:0] bandgap_level,
    // code back to the block
    output logic [9:0] analog_code
);
    logic [9:0] pick; // code of the selected input
    logic [9:0] held_ff = 10'h155; // code presented to the block

    // selected input as unsigned code, ground and reserved give zero
    always_comb
    begin
        pick = bandgap_select ? bandgap_level : 10'h000;
        for (int i = 0; i < 8; i++)
            if (pin_select[i])
                pick = pin_level[i*10 +: 10];
    end

    // steady code only while converting, a changing pattern otherwise
    always @(posedge core_clk)
        if (sample_hold && analog_power)
            held_ff <= pick;
        else
            held_ff <= ~held_ff;

    assign analog_code = held_ff;
endmodule : acrc_analog_model

// ### tb/acrc_top_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module acrc_top_tb;
    //------------------------------------------------------------------
    // signals
    //------------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic vector_taken = 1'b0;
    logic [7:0] reg_rdata, pin_select, rv;
    logic irq, analog_power, sample_hold, ref_internal_on;
    logic bandgap_select, ground_select;
    logic [1:0] reference_choice;
    logic [9:0] analog_code;
    logic [9:0] bandgap_level = 10'h2A5;
    logic [79:0] pin_level;
    int n_errors = 0;
    int checks = 0;
    int sh_cnt = 0;

    always #2.5 core_clk = ~core_clk;
    // cycles spent converting
    always @(posedge core_clk)
        if (sample_hold === 1'b1)
            sh_cnt <= sh_cnt + 1;

    acrc_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vector_taken(vector_taken),
        .irq(irq), .analog_code(analog_code), .analog_power(analog_power),
        .sample_hold(sample_hold), .reference_choice(reference_choice),
        .ref_internal_on(ref_internal_on), .pin_select(pin_select),
        .bandgap_select(bandgap_select), .ground_select(ground_select));
    acrc_analog_model model_u (.core_clk(core_clk),
        .analog_power(analog_power), .sample_hold(sample_hold),
        .pin_select(pin_select), .bandgap_select(bandgap_select),
        .pin_level(pin_level), .bandgap_level(bandgap_level),
        .analog_code(analog_code));

    //------------------------------------------------------------------
    // tasks and expectation functions
    //------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one write cycle, then one idle cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    // read strobe, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
        @(posedge core_clk);
    endtask : rd

    task automatic wait_idle;
        for (int w = 0; w < 5000 && sample_hold !== 1'b0; w++)
            @(posedge core_clk);
        // a conversion that never ends counts as a mismatch
        chk(sample_hold, 1'b0);
    endtask : wait_idle

    // sixteen-bit data view of a code
    function automatic logic [15:0] view(logic [9:0] c, logic left);
        return left ? {c, 6'h00} : {6'h00, c};
    endfunction : view

    function automatic logic [9:0] level(logic [3:0] ch);
        if (ch == 4'hE)
            return bandgap_level;
        return ch[3] ? 10'h000 : pin_level[ch[2:0]*10 +: 10];
    endfunction : level

    // one conversion with selection changes while busy
    task automatic conv(input logic [7:0] s, input logic [2:0] dv,
                        input int ticks);
        int d;
        logic [15:0] v;
        d = (dv < 3'h2) ? 2 : (1 << dv);
        v = view(level(s[3:0]), s[5]);
        wr(4'h0, s);
        // live selection settles one cycle after the register write
        @(negedge core_clk);
        chk(ref_internal_on, &s[7:6]);
        chk({ground_select, bandgap_select, pin_select}, {s[3:0] == 4'hF,
            s[3:0] == 4'hE, s[3] ? 8'h00 : 8'h01 << s[2:0]});
        @(posedge core_clk);
        sh_cnt = 0;
        wr(4'h1, {5'b11000, dv});
        wr(4'h0, s ^ 8'hC3);
        wr(4'h1, {5'b10000, dv});
        rd(4'h1, rv);
        chk(rv[6], 1'b1);
        chk(reference_choice, s[7:6]);
        wait_idle();
        chk(sh_cnt >= ticks*d - 3 && sh_cnt <= ticks*d + d + 3, 1);
        chk(reference_choice, s[7:6] ^ 2'h3);
        rd(4'h1, rv);
        chk(rv, {5'b10010, dv});
        rd(4'h2, rv);
        chk(rv, v[7:0]);
        rd(4'h3, rv);
        chk(rv, v[15:8]);
        wr(4'h0, s ^ 8'hE3);
        v = view(level(s[3:0]), !s[5]);
        rd(4'h3, rv);
        chk(rv, v[15:8]);
        wr(4'h1, {5'b10010, dv});
        rd(4'h1, rv);
        chk(rv[4], 1'b0);
    endtask : conv

    task automatic end_sim;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hBD870CD4));
        for (int i = 0; i < 8; i++)
            pin_level[i*10 +: 10] = 10'($urandom);
        pin_level[9:0] = 10'h000;
        pin_level[79:70] = 10'h3FF;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 10; a++)
        begin
            rd(4'(a), rv);
            chk(rv, 8'h00);
        end
        wr(4'h9, 8'hFF);
        wr(4'h0, 8'hFF);
        rd(4'h0, rv);
        chk(rv, 8'hEF);
        $display("test registers done");
        for (int i = 0; i < 16; i++)
            conv({2'(i), 1'($urandom), 1'b0, 4'(i)}, 3'(i), i ? 13 : 25);
        $display("test conversions done");
        rd(4'h2, rv);
        wr(4'h0, 8'h07);
        wr(4'h1, 8'hC0);
        wait_idle();
        rd(4'h3, rv);
        chk(rv, 8'h00);
        rd(4'h1, rv);
        chk(rv[4], 1'b1);
        $display("test blocked update done");
        wr(4'h5, 8'h03);
        wr(4'h1, 8'h90);
        rd(4'h4, rv);
        chk(irq, 1'b0);
        wr(4'h1, 8'hC0);
        repeat (5) @(posedge core_clk);
        wr(4'h1, 8'h00);
        chk({analog_power, sample_hold, irq}, 3'h1);
        rd(4'h1, rv);
        chk(rv, 8'h00);
        rd(4'h4, rv);
        chk({rv, 7'h00, irq}, {8'h02, 8'h00});
        wr(4'h5, 8'h00);
        wr(4'h1, 8'hC8);
        wait_idle();
        chk(irq, 1'b1);
        vector_taken <= 1'b1;
        @(posedge core_clk);
        vector_taken <= 1'b0;
        @(posedge core_clk);
        rd(4'h1, rv);
        chk({rv[4], irq}, 2'h0);
        wr(4'h5, 8'h01);
        chk(irq, 1'b1);
        rd(4'h4, rv);
        chk({rv, 7'h00, irq}, {8'h01, 8'h00});
        $display("test abort and interrupt done");
        end_sim();
    end

    // watchdog cuts a hang short
    initial
    begin
        #200000;
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule : acrc_top_tb
